/* File: design/tbs_pkg.sv */
// shared constants and types for the boundary-scan test access port controller
`default_nettype none
package tbs_pkg;
    // register widths
    localparam int IR_W  = 8;
    localparam int BSR_W = 52;
    localparam int BCR_W = 3;
    localparam int ID_W  = 32;

    // reset and capture values
    localparam logic [IR_W-1:0]  IR_RESET  = 8'h81;
    localparam logic [IR_W-1:0]  IR_STATUS = 8'h81;
    localparam logic [BCR_W-1:0] BCR_RESET = 3'h2;
    localparam int               BSR_OE_HI = 51;
    localparam int               BSR_OE_LO = 48;
    localparam logic [3:0]       BSR_OE_RESET = 4'h0;

    // instruction opcodes; all but the identification code are arbitrary
    localparam logic [IR_W-1:0] OP_IDCODE   = 8'h81;
    localparam logic [IR_W-1:0] OP_BOUNDARY = 8'h82;
    localparam logic [IR_W-1:0] OP_BCR      = 8'h87;
    localparam logic [IR_W-1:0] OP_RUNTEST  = 8'h0A;
    localparam logic [IR_W-1:0] OP_BYPASS   = 8'hFF;

    // boundary-control value for parallel_signature_analysis
    localparam logic [BCR_W-1:0] BCR_PARALLEL_SIGNATURE_ANALYSIS = 3'h2;

    // consecutive high mode-select edges that must reach reset
    localparam logic [2:0] RESET_TMS_EDGES = 3'h5;

    // synchroniser vector layout
    localparam int SY_TCK = 0;
    localparam int SY_TMS = 1;
    localparam int SY_TDI = 2;
    localparam int SY_OE0 = 3;
    localparam int SY_OE1 = 4;
    localparam int SY_W   = 5;

    // controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } tbs_state_t;

    // selected data register
    typedef enum logic [1:0] {
        DR_BYPASS = 2'h0,
        DR_BSR    = 2'h1,
        DR_BCR    = 2'h2,
        DR_ID     = 2'h3
    } tbs_dr_t;
endpackage
`default_nettype wire

/* File: design/tbs_tap.sv */
// boundary-scan test access port controller with its test registers
`default_nettype none
module tbs_tap
    import tbs_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001 // arbitrary identification value
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  tck_pin,
    input  wire logic                  tms_pin,
    input  wire logic                  tms_driven,
    input  wire logic                  tdi_pin,
    input  wire logic                  tdi_driven,
    input  wire logic [1:0]            oe_n_pin,
    input  wire logic [1:0]            oe_n_driven,
    input  wire logic [BSR_W-1:0]      bsr_capture,
    output logic                       tdo_out,
    output logic                       tdo_oe,
    output logic [1:0]                 oe_n_sync,
    output tbs_pkg::tbs_state_t        tap_state,
    output logic                       test_logic_en,
    output logic [IR_W-1:0]            instr,
    output logic [BSR_W-1:0]           bsr_out,
    output logic [BCR_W-1:0]           bcr_out,
    output logic                       test_run
);
    import tbs_pkg::*;

    // instruction to data register decode, used by capture, shift and output mux
    function automatic tbs_dr_t dr_select(input logic [IR_W-1:0] op);
        case (op)
            OP_IDCODE:   dr_select = DR_ID;
            OP_BOUNDARY: dr_select = DR_BSR;
            OP_BCR:      dr_select = DR_BCR;
            default:     dr_select = DR_BYPASS; // unsupported opcodes fall to bypass
        endcase
    endfunction

    logic [SY_W-1:0]  pin_raw;
    logic [SY_W-1:0]  sync1_q;
    logic [SY_W-1:0]  sync2_q;
    logic             tck_prev_q;
    logic             tck_rise;
    logic             tck_fall;
    logic             tms_s;
    logic             tdi_s;
    tbs_state_t       state_q;
    tbs_state_t       state_d;
    tbs_dr_t          dr_sel;
    logic [IR_W-1:0]  ir_sh_q;
    logic [IR_W-1:0]  ir_q;
    logic [BSR_W-1:0] bsr_sh_q;
    logic [BSR_W-1:0] bsr_q;
    logic [BCR_W-1:0] bcr_sh_q;
    logic [BCR_W-1:0] bcr_q;
    logic [ID_W-1:0]  id_sh_q;
    logic             byp_sh_q;
    logic             tdo_q;
    logic             tdo_oe_q;
    logic             run_q;
    logic             dr_lsb;
    logic [2:0]       tms_cnt_q;

    // pull-ups: an undriven pin reads high before it is synchronised
    assign pin_raw[SY_TCK] = tck_pin;
    assign pin_raw[SY_TMS] = tms_driven ? tms_pin : 1'b1;
    assign pin_raw[SY_TDI] = tdi_driven ? tdi_pin : 1'b1;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_oe_pull
            assign pin_raw[SY_OE0+g] = oe_n_driven[g] ? oe_n_pin[g] : 1'b1;
        end
    endgenerate

    // two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // test-clock edge detection on the synchronised copy
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tck_prev_q <= 1'b1;
        end else begin
            tck_prev_q <= sync2_q[SY_TCK];
        end
    end

    assign tck_rise  = sync2_q[SY_TCK] & ~tck_prev_q;
    assign tck_fall  = ~sync2_q[SY_TCK] & tck_prev_q;
    assign tms_s     = sync2_q[SY_TMS];
    assign tdi_s     = sync2_q[SY_TDI];
    assign oe_n_sync = {sync2_q[SY_OE1], sync2_q[SY_OE0]};
    assign dr_sel    = dr_select(ir_q);

    // next-state graph; select, capture, exit and update states last one clock
    always_comb begin
        case (state_q)
            ST_RESET:    state_d = tms_s ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_d = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_d = tms_s ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_d = tms_s ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_d = tms_s ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_d = tms_s ? ST_SEL_DR   : ST_IDLE;
            default:     state_d = ST_RESET; // a corrupted code recovers to reset
        endcase
    end

    // state register moves only on a rising test-clock edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // instruction shift stage: fixed status on capture, shift toward the lsb
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ir_sh_q <= IR_RESET;
        end else if (tck_rise && state_q == ST_CAP_IR) begin
            ir_sh_q <= IR_STATUS;
        end else if (tck_rise && state_q == ST_SHIFT_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
        end
    end

    // current instruction; updates on the falling edge inside update-ir
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == ST_RESET) begin
            ir_q <= IR_RESET;
        end else if (tck_fall && state_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // data shift stages: capture on the edge leaving capture-dr, shift only
    // the register that the instruction selects
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bsr_sh_q <= '0;
            bcr_sh_q <= BCR_RESET;
            id_sh_q  <= ID_VALUE;
            byp_sh_q <= 1'b0;
        end else if (tck_rise && state_q == ST_CAP_DR) begin
            case (dr_sel)
                DR_BSR:  bsr_sh_q <= bsr_capture;
                DR_BCR:  bcr_sh_q <= bcr_q;
                DR_ID:   id_sh_q  <= ID_VALUE;
                default: byp_sh_q <= 1'b0;
            endcase
        end else if (tck_rise && state_q == ST_SHIFT_DR) begin
            case (dr_sel)
                DR_BSR:  bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_W-1:1]};
                DR_BCR:  bcr_sh_q <= {tdi_s, bcr_sh_q[BCR_W-1:1]};
                DR_ID:   id_sh_q  <= {tdi_s, id_sh_q[ID_W-1:1]};
                default: byp_sh_q <= tdi_s;
            endcase
        end
    end

    // boundary shadow in one process: the output-control cells reload in reset,
    // the rest have no reset value and are cleared by sys_rst only for simulation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bsr_q[BSR_OE_HI:BSR_OE_LO] <= BSR_OE_RESET;
            bsr_q[BSR_OE_LO-1:0]       <= '0;
        end else if (state_q == ST_RESET) begin
            bsr_q[BSR_OE_HI:BSR_OE_LO] <= BSR_OE_RESET;
        end else if (tck_fall && state_q == ST_UPD_DR && dr_sel == DR_BSR) begin
            bsr_q <= bsr_sh_q;
        end
    end

    // control shadow reloads every clock while the controller sits in reset
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == ST_RESET) begin
            bcr_q <= BCR_RESET;
        end else if (tck_fall && state_q == ST_UPD_DR && dr_sel == DR_BCR) begin
            bcr_q <= bcr_sh_q;
        end
    end

    // least significant bit of the selected data register
    always_comb begin
        case (dr_sel)
            DR_BSR:  dr_lsb = bsr_sh_q[0];
            DR_BCR:  dr_lsb = bcr_sh_q[0];
            DR_ID:   dr_lsb = id_sh_q[0];
            default: dr_lsb = byp_sh_q;
        endcase
    end

    // serial output changes only on falling edges, giving the tester half a
    // period of settled data before its own rising-edge capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tdo_q    <= 1'b1;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);
            if (state_q == ST_SHIFT_IR) begin
                tdo_q <= ir_sh_q[0];
            end else if (state_q == ST_SHIFT_DR) begin
                tdo_q <= dr_lsb;
            end
        end
    end

    // the chosen test operation runs only while idling under the run instruction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= (state_q == ST_IDLE) && (ir_q == OP_RUNTEST);
        end
    end

    assign tdo_out       = tdo_q;
    assign tdo_oe        = tdo_oe_q;
    assign tap_state     = state_q;
    assign test_logic_en = (state_q != ST_RESET);
    assign instr         = ir_q;
    assign bsr_out       = bsr_q;
    assign bcr_out       = bcr_q;
    assign test_run      = run_q;

    // helper: run of consecutive rising edges with mode-select high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tms_cnt_q <= '0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_cnt_q <= '0;
            end else if (tms_cnt_q != RESET_TMS_EDGES) begin
                tms_cnt_q <= tms_cnt_q + 3'h1;
            end
        end
    end

    // protocol checks, all on the system clock and quiet while sys_rst is high
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_TDO_ON_FALL: assert property (
        $changed(tdo_out) || $changed(tdo_oe) |-> $past(tck_fall))
        else $error("serial output changed without a falling test-clock edge");
    AST_STATE_ON_RISE: assert property (
        $changed(state_q) |-> $past(tck_rise))
        else $error("controller state moved without a rising test-clock edge");
    AST_TMS_PULLUP: assert property (
        (!tms_driven)[*3] |-> tms_s)
        else $error("undriven mode-select did not read high");
    AST_TDI_PULLUP: assert property (
        (!tdi_driven)[*3] |-> tdi_s)
        else $error("undriven data input did not read high");
    AST_OE_PULLUP: assert property (
        (!oe_n_driven[0] && !oe_n_driven[1])[*3] |-> (oe_n_sync == 2'h3))
        else $error("undriven output enables did not read high");
    AST_FIVE_TO_RESET: assert property (
        (tms_cnt_q == RESET_TMS_EDGES) |-> (state_q == ST_RESET))
        else $error("five high mode-select edges did not reach reset");
    AST_RESET_VALUES: assert property (
        (state_q == ST_RESET) |=> (ir_q == IR_RESET && bcr_q == BCR_RESET
            && bsr_q[BSR_OE_HI:BSR_OE_LO] == BSR_OE_RESET))
        else $error("reset state did not load instruction and control values");
    AST_SELECT_LEAVES: assert property (
        (tck_rise && state_q == ST_SEL_DR) |=> (state_q == ST_CAP_DR || state_q == ST_SEL_IR))
        else $error("select state was not left on the next test clock");
    AST_TDO_FLOATS: assert property (
        (tck_fall && state_q != ST_SHIFT_DR && state_q != ST_SHIFT_IR) |=> !tdo_oe)
        else $error("serial output driven outside the shift states");
    AST_ID_CAPTURE: assert property (
        (tck_rise && state_q == ST_CAP_DR && dr_sel == DR_ID) |=> (id_sh_q == ID_VALUE))
        else $error("identification register did not capture its value");
    AST_RUN_IDLE: assert property (
        test_run |-> $past(state_q == ST_IDLE))
        else $error("test operation ran outside run-test/idle");
    AST_SEL_IR_LEAVES: assert property (
        (tck_rise && state_q == ST_SEL_IR) |=> (state_q == ST_CAP_IR || state_q == ST_RESET))
        else $error("instruction select state was not left on the next test clock");
    AST_UNSTABLE_ONE_TCK: assert property (
        (tck_rise && (state_q inside {ST_SEL_DR, ST_CAP_DR, ST_EXIT1_DR, ST_EXIT2_DR,
            ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_EXIT1_IR, ST_EXIT2_IR, ST_UPD_IR}))
        |=> (state_q != $past(state_q)))
        else $error("single-cycle state held across a rising test-clock edge");
    AST_ONE_HOT: assert property (
        $onehot(state_q))
        else $error("controller state code is not one-hot");
    AST_TDO_IR_LSB: assert property (
        (tck_fall && state_q == ST_SHIFT_IR) |=> (tdo_out == $past(ir_sh_q[0])))
        else $error("instruction scan did not drive the instruction lsb");
    AST_TDO_DR_LSB: assert property (
        (tck_fall && state_q == ST_SHIFT_DR) |=> (tdo_out == $past(dr_lsb)))
        else $error("data scan did not drive the selected register lsb");

    COV_IR_SCAN: cover property (state_q == ST_UPD_IR && tck_fall);
    COV_DR_SHIFT: cover property (state_q == ST_SHIFT_DR && tck_rise);
    COV_TMS_RESET: cover property (tms_cnt_q == RESET_TMS_EDGES);
    COV_IR_RESUME: cover property (state_q == ST_EXIT2_IR && tck_rise && !tms_s);
    COV_BYPASS_SHIFT: cover property (state_q == ST_SHIFT_DR && tck_rise && dr_sel == DR_BYPASS);
endmodule
`default_nettype wire

/* File: tb/tbs_tester.sv */
// behavioural test bus master: drives test clock, mode select and serial data, samples tdo
`default_nettype none
module tbs_tester (
    input  wire logic clk,
    input  wire logic tdo_out,
    input  wire logic tdo_oe,
    output var logic  tck,
    output var logic  tms,
    output var logic  tms_drv,
    output var logic  tdi,
    output var logic  tdi_drv,
    output var logic  tdo_moved
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LOW_CLK  = 12; // low half in clk cycles
    localparam int HIGH_CLK = 13; // 25 clk in all, 125 ns

    // test clock parked high between frames, lines driven high
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tms_drv = 1'b1;
        tdi = 1'b1;
        tdi_drv = 1'b1;
        tdo_moved = 1'b0;
    end

    // one test-clock period: new levels at the fall, tdo taken just before the rise
    task automatic step(input logic m, input logic d, input logic m_en, input logic d_en,
                        output logic seen, output logic seen_oe);
        @(posedge clk);
        #1;
        tck = 1'b0;
        tms = m_en ? m : ~tms;
        tms_drv = m_en;
        tdi = d_en ? d : ~tdi;
        tdi_drv = d_en;
        repeat (LOW_CLK) @(posedge clk);
        #1;
        seen = tdo_out;
        seen_oe = tdo_oe;
        // levels were held for the whole low half before this rise
        tck = 1'b1;
        repeat (HIGH_CLK - 1) @(posedge clk);
        #1;
        // the device may only move tdo on falling edges
        if (tdo_out !== seen || tdo_oe !== seen_oe) tdo_moved = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: tb/test_boundary_scan_tap_controller.sv */
// self-checking bench for the test access port controller
`default_nettype none
module test_boundary_scan_tap_controller;
    import tbs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [ID_W-1:0] TB_ID = 32'h5A3C_0F1B; // arbitrary identification value

    logic             clk;
    logic             sys_rst;
    logic             tck;
    logic             tms;
    logic             tms_drv;
    logic             tdi;
    logic             tdi_drv;
    logic             tdo_moved;
    logic [1:0]       oe_n_pin;
    logic [1:0]       oe_n_drv;
    logic [BSR_W-1:0] bsr_cap;
    logic             tdo_out;
    logic             tdo_oe;
    logic [1:0]       oe_n_sync;
    tbs_state_t       tap_state;
    logic             test_logic_en;
    logic [IR_W-1:0]  instr;
    logic [BSR_W-1:0] bsr_out;
    logic [BCR_W-1:0] bcr_out;
    logic             test_run;
    logic             so;
    logic             so_oe;
    logic [63:0]      dout;
    int               n_fail;
    int               compares;
    int               cycles;

    tbs_tap #(.ID_VALUE(TB_ID)) tbs_tap_i (
        .clk(clk), .sys_rst(sys_rst), .tck_pin(tck), .tms_pin(tms), .tms_driven(tms_drv),
        .tdi_pin(tdi), .tdi_driven(tdi_drv), .oe_n_pin(oe_n_pin), .oe_n_driven(oe_n_drv),
        .bsr_capture(bsr_cap), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .oe_n_sync(oe_n_sync),
        .tap_state(tap_state), .test_logic_en(test_logic_en), .instr(instr),
        .bsr_out(bsr_out), .bcr_out(bcr_out), .test_run(test_run));

    tbs_tester tbs_tester_i (
        .clk(clk), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
        .tms_drv(tms_drv), .tdi(tdi), .tdi_drv(tdi_drv), .tdo_moved(tdo_moved));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // scans take about 6.2k clk; the ceiling leaves ample slack
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 40000) begin
            $display("timeout after %0d cycles", cycles);
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // walk the controller with driven mode-select levels, first bit first
    task automatic walk(input logic [7:0] bits, input int n);
        for (int i = 0; i < n; i++) tbs_tester_i.step(bits[i], 1'b0, 1'b1, 1'b1, so, so_oe);
    endtask

    // full scan from idle back to idle, data shifted lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din, input logic d_en);
        dout = '0;
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        check("shift state", 64'(tap_state), ir ? ST_SHIFT_IR : ST_SHIFT_DR);
        check("tdo float before shift", 64'(tdo_oe), 0);
        for (int i = 0; i < n; i++) begin
            tbs_tester_i.step(i == n - 1, din[i], 1'b1, d_en, so, so_oe);
            dout[i] = so;
            check("tdo enable in shift", 64'(so_oe), 1);
        end
        walk(8'h01, 1);
        check("tdo float after exit", 64'(so_oe), 0);
        walk(8'h00, 1);
        check("back to idle", 64'(tap_state), ST_IDLE);
    endtask

    task automatic t_reset_values();
        check("reset state", 64'(tap_state), ST_RESET);
        check("normal function", 64'(test_logic_en), 0);
        check("reset instr", 64'(instr), IR_RESET);
        check("reset oe cells", 64'(bsr_out[BSR_OE_HI:BSR_OE_LO]), BSR_OE_RESET);
        check("reset control", 64'(bcr_out), 3'b010);
    endtask

    task automatic t_idcode();
        walk(8'h00, 2);
        check("idle held", 64'(tap_state), ST_IDLE);
        check("test logic on", 64'(test_logic_en), 1);
        scan(1'b0, 32, 64'h0, 1'b1);
        check("id register", dout, 64'(TB_ID));
    endtask

    task automatic t_boundary();
        scan(1'b1, 8, 64'(OP_BOUNDARY), 1'b1);
        check("ir capture", dout, 64'(IR_STATUS));
        check("instr update", 64'(instr), OP_BOUNDARY);
        bsr_cap = 52'h3_96C1_E07B_D245;
        scan(1'b0, 52, 64'h000A_5C3F_0E1D_2B47, 1'b1);
        check("bsr capture", dout, 64'(bsr_cap));
        check("bsr update", 64'(bsr_out), 64'h000A_5C3F_0E1D_2B47);
        scan(1'b1, 8, 64'(OP_BCR), 1'b1);
        scan(1'b0, 3, 64'h5, 1'b1);
        check("bcr capture", dout, 64'(BCR_RESET));
        check("bcr update", 64'(bcr_out), 3'b101);
    endtask

    task automatic t_bypass();
        logic [IR_W-1:0] ops [2];
        ops[0] = OP_BYPASS;
        ops[1] = 8'h33;
        for (int k = 0; k < 2; k++) begin
            scan(1'b1, 8, 64'(ops[k]), 1'b1);
            scan(1'b0, 8, 64'hC5, 1'b1);
            check("bypass one stage", dout, 64'h8A);
        end
        // open input with the pin toggling every test clock must still shift in ones
        scan(1'b0, 4, 64'h0, 1'b0);
        check("tdi pull-up", dout, 64'hE);
    endtask

    task automatic t_run();
        scan(1'b1, 8, 64'(OP_RUNTEST), 1'b1);
        walk(8'h00, 1);
        check("test runs in idle", 64'(test_run), 1);
        walk(8'h01, 1);
        check("select dr", 64'(tap_state), ST_SEL_DR);
        check("test stops", 64'(test_run), 0);
        walk(8'h01, 1);
        check("select ir", 64'(tap_state), ST_SEL_IR);
        walk(8'h01, 1);
        check("ir select to reset", 64'(tap_state), ST_RESET);
        walk(8'h00, 1);
        // instruction scan through pause and back into shift: two shifts of zeros
        walk(8'h53, 8);
        check("ir resume shift", 64'(tap_state), ST_SHIFT_IR);
        walk(8'h03, 3);
        check("ir after pause", 64'(instr), 8'h20);
    endtask

    task automatic t_tms_reset();
        scan(1'b1, 8, 64'(OP_BOUNDARY), 1'b1);
        walk(8'h05, 5);
        check("pause held", 64'(tap_state), ST_PAUSE_DR);
        // mode-select left open while its pin shows garbage
        for (int i = 0; i < 4; i++) tbs_tester_i.step(1'b0, 1'b0, 1'b0, 1'b1, so, so_oe);
        check("four open clocks", 64'(tap_state), ST_SEL_IR);
        tbs_tester_i.step(1'b0, 1'b0, 1'b0, 1'b1, so, so_oe);
        check("five open clocks", 64'(tap_state), ST_RESET);
        check("instr reloaded", 64'(instr), IR_RESET);
        check("oe cells cleared", 64'(bsr_out[BSR_OE_HI:BSR_OE_LO]), BSR_OE_RESET);
        check("control reloaded", 64'(bcr_out), BCR_RESET);
    endtask

    task automatic t_oe_pull();
        @(posedge clk);
        #1;
        oe_n_pin = 2'b00;
        oe_n_drv = 2'b00;
        repeat (4) @(posedge clk);
        check("oe open reads high", 64'(oe_n_sync), 2'b11);
        #1;
        oe_n_pin = 2'b01;
        oe_n_drv = 2'b11;
        repeat (4) @(posedge clk);
        check("oe driven", 64'(oe_n_sync), 2'b01);
    endtask

    initial begin
        n_fail = 0;
        compares = 0;
        cycles = 0;
        sys_rst = 1'b1;
        oe_n_pin = 2'b11;
        oe_n_drv = 2'b11;
        bsr_cap = '0;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        t_reset_values();
        t_idcode();
        t_boundary();
        t_bypass();
        t_run();
        t_tms_reset();
        t_oe_pull();
        check("tdo steady while tck high", 64'(tdo_moved), 0);
        print_verdict();
    end
endmodule
`default_nettype wire
